// File: core/id_filter_pkg.sv
// Purpose: constants for the identifier tag and mask register set
// Assumes: byte-wide special-function register port, one clock
// Notes: offsets are register-space addresses
`default_nettype none
package id_filter_pkg;
    localparam logic [7:0] TAG_REG_FIRST_ADDR = 8'hBC;
    localparam logic [7:0] TAG_REG_SECOND_ADDR = 8'hBD;
    localparam logic [7:0] TAG_REG_THIRD_ADDR = 8'hBE;
    localparam logic [7:0] TAG_REG_FOURTH_ADDR = 8'hBF;
    localparam logic [7:0] MASK_REG_FIRST_ADDR = 8'hC4;
    localparam logic [7:0] MASK_REG_SECOND_ADDR = 8'hC5;
    localparam logic [7:0] MASK_REG_THIRD_ADDR = 8'hC6;
    localparam logic [7:0] MASK_REG_FOURTH_ADDR = 8'hC7;
    // Field positions (fourth register, except STD_ID_LSB in the second) and byte store sizes
    localparam int RTR_POS = 2;
    localparam int RB1_POS = 1;
    localparam int RB0_POS = 0;
    localparam int EXT_MASK_POS = 0;
    localparam int LOW_ID_LSB = 3;
    localparam int STD_ID_LSB = 5;
    localparam int REG_COUNT = 8;
    localparam int ADDR_W = 3;
endpackage
`default_nettype wire

// File: core/id_reg_file.sv
// Purpose: small byte register file holding tag and mask bytes
// Assumes: one write port, registered read data
// Notes: no reset; contents are undefined until written
`timescale 1ns/1ps
`default_nettype none
module id_reg_file #(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [DEPTH*8-1:0] all_bytes
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rd_data_d;

    always_comb begin
        rd_data_d = mem_q[rd_addr];
    end

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= rd_data_d;
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            all_bytes[i*8 +: 8] = mem_q[i];
        end
    end
endmodule
`default_nettype wire

// File: core/can_id_tag_mask_filter.sv
// Purpose: identifier tag and mask registers of one message object, with acceptance test
// Assumes: software accesses by the special-function register port on clk_sys
// Notes: registers hold no reset value; software must load them first
//        reserved bits are stored and read back exactly as written
//        masks act on the receive compare only
//
// Behaviour
// - Identifier mask bit 0 forces match; 1 requires received bit equal tag.
// - Fourth mask bit 2 masks remote-request comparison the same way.
// - Fourth mask bit 0 masks the extension-format comparison the same way.
// - Masks only filter received frames; transmit path never sees them.
// - Tag and mask registers have no reset value; software loads them first.
// - Reserved bit positions read back exactly as written.
// - Extended identifier spans first three tag registers and fourth bits 7-3.
// - Extended fourth tag holds remote-request, reserved1, reserved0 tags at 2,1,0.
// - Standard fourth tag holds remote-request at 2, reserved0 at 0.
// - Standard mask bits 10-3 in first mask, 2-0 in second bits 7-5.
// - Both formats share the same four tag and four mask addresses.
// - Standard tag bits 10-3 in first tag, 2-0 in second bits 7-5.
`timescale 1ns/1ps
`default_nettype none
module can_id_tag_mask_filter (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic ext_format,
    input wire logic rx_valid,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    output logic rx_accept,
    output logic rx_accept_valid,
    output logic [28:0] tx_id,
    output logic tx_rtr,
    output logic tx_ide
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [3:0] decode(input logic [7:0] a);
        // Bit 3 flags a hit, low bits index the byte store
        if (a >= id_filter_pkg::TAG_REG_FIRST_ADDR
                && a <= id_filter_pkg::TAG_REG_FOURTH_ADDR) begin
            decode = {1'b1, 1'b0, 2'(a - id_filter_pkg::TAG_REG_FIRST_ADDR)};
        end else if (a >= id_filter_pkg::MASK_REG_FIRST_ADDR
                     && a <= id_filter_pkg::MASK_REG_FOURTH_ADDR) begin
            decode = {1'b1, 1'b1, 2'(a - id_filter_pkg::MASK_REG_FIRST_ADDR)};
        end else begin
            decode = 4'h0;
        end
    endfunction

    logic [3:0] dec;
    logic wr_sel;
    logic rd_sel;
    logic [7:0] rd_byte;
    logic [63:0] bytes;
    logic hit_q;
    logic hit_d;

    always_comb begin
        dec = decode(sfr_addr);
        wr_sel = sfr_wr && dec[3];
        rd_sel = sfr_rd && dec[3];
    end

    // ------------------------------------------------------------
    // Byte store
    // ------------------------------------------------------------
    // No reset, no masking of reserved bits on write or read
    id_reg_file #(
        .DEPTH(id_filter_pkg::REG_COUNT),
        .AW(id_filter_pkg::ADDR_W)
    ) u_regs (
        .clk_sys(clk_sys),
        .wr_en(wr_sel),
        .wr_addr(dec[2:0]),
        .wr_data(sfr_wdata),
        .rd_addr(dec[2:0]),
        .rd_data(rd_byte),
        .all_bytes(bytes)
    );

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        hit_d = rd_sel;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= hit_d;
        end
    end

    // Unmapped reads return zero; data lags the read strobe by one cycle
    always_comb begin
        sfr_hit = hit_q;
        sfr_rdata = hit_q ? rd_byte : 8'h00;
    end

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    // Tag and mask share one byte layout, so one packer serves both
    function automatic logic [28:0] pack_id(
        input logic [7:0] b1,
        input logic [7:0] b2,
        input logic [7:0] b3,
        input logic [7:0] b4,
        input logic ext
    );
        if (ext) begin
            pack_id = {b1, b2, b3, b4[7:id_filter_pkg::LOW_ID_LSB]};
        end else begin
            // Upper bits held low so leftovers of the long format never count
            pack_id = {18'h00000, b1, b2[7:id_filter_pkg::STD_ID_LSB]};
        end
    endfunction

    // Mask bit low forces the compare true
    function automatic logic bit_ok(
        input logic en,
        input logic got,
        input logic want
    );
        bit_ok = !en || (got == want);
    endfunction

    logic [7:0] t1;
    logic [7:0] t2;
    logic [7:0] t3;
    logic [7:0] t4;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [7:0] m3;
    logic [7:0] m4;
    logic [28:0] tag_id;
    logic [28:0] mask_id;
    logic tag_rtr;
    logic mask_rtr;
    logic mask_ext;

    always_comb begin
        t1 = bytes[7:0];
        t2 = bytes[15:8];
        t3 = bytes[23:16];
        t4 = bytes[31:24];
        m1 = bytes[39:32];
        m2 = bytes[47:40];
        m3 = bytes[55:48];
        m4 = bytes[63:56];
        tag_id = pack_id(t1, t2, t3, t4, ext_format);
        mask_id = pack_id(m1, m2, m3, m4, ext_format);
        tag_rtr = t4[id_filter_pkg::RTR_POS];
        mask_rtr = m4[id_filter_pkg::RTR_POS];
        mask_ext = m4[id_filter_pkg::EXT_MASK_POS];
    end

    // ------------------------------------------------------------
    // Acceptance test
    // ------------------------------------------------------------
    logic [28:0] rx_cmp;
    logic id_ok;
    logic rtr_ok;
    logic ext_ok;
    logic frame_match;
    logic acc_d;
    logic acc_q;
    logic accv_d;
    logic accv_q;

    always_comb begin
        // Short format ignores the upper received bits entirely
        rx_cmp = ext_format ? rx_id : {18'h00000, rx_id[10:0]};
        id_ok = ((rx_cmp ^ tag_id) & mask_id) == 29'h00000000;
        rtr_ok = bit_ok(mask_rtr, rx_rtr, tag_rtr);
        ext_ok = bit_ok(mask_ext, rx_ide, ext_format);
        frame_match = id_ok && rtr_ok && ext_ok;
        acc_d = rx_valid && frame_match;
        accv_d = rx_valid;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            acc_q <= 1'b0;
            accv_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            accv_q <= accv_d;
        end
    end

    // ------------------------------------------------------------
    // Verdict outputs
    // ------------------------------------------------------------
    always_comb begin
        rx_accept = acc_q;
        rx_accept_valid = accv_q;
    end

    // ------------------------------------------------------------
    // Transmit view
    // ------------------------------------------------------------
    // Built from tags and ext_format only, so mask writes never disturb a pending send
    always_comb begin
        tx_id = tag_id;
        tx_rtr = tag_rtr;
        tx_ide = ext_format;
    end
endmodule
`default_nettype wire

// File: test/id_filter_props.sv
// Purpose: port checks of the tag and mask filter
// Assumes: shadow bytes mirror every mapped write
// Notes: filter checks armed once all eight bytes were written, read-back once its byte was, as contents start undefined
`timescale 1ns/1ps
`default_nettype none
module id_filter_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic ext_format,
    input wire logic rx_valid,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    input wire logic rx_accept,
    input wire logic rx_accept_valid,
    input wire logic [28:0] tx_id,
    input wire logic tx_rtr
);
    logic [7:0] r_q [8];
    logic [7:0] w_q;
    logic [28:0] tg, mk;
    logic [2:0] ix;
    logic map, ok_r, ok_e, idm;
    assign ix = {sfr_addr[6], sfr_addr[1:0]};
    assign map = sfr_addr[7:2] == 6'h2F || sfr_addr[7:2] == 6'h31;
    assign tg = ext_format ? {r_q[0], r_q[1], r_q[2], r_q[3][7:3]} : {18'h0, r_q[0], r_q[1][7:5]};
    assign mk = ext_format ? {r_q[4], r_q[5], r_q[6], r_q[7][7:3]} : {18'h0, r_q[4], r_q[5][7:5]};
    assign idm = ((rx_id ^ tg) & mk) == 29'h0;
    assign ok_r = !r_q[7][2] || rx_rtr == r_q[3][2];
    assign ok_e = !r_q[7][0] || rx_ide == ext_format;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            w_q <= 8'h00;
        end else if (sfr_wr && map) begin
            w_q[ix] <= 1'b1;
            r_q[ix] <= sfr_wdata;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    chk_valid_pulse: assert property (rx_valid |=> rx_accept_valid)
        else $error("no verdict after frame");
    chk_accept_qual: assert property (rx_accept |-> rx_accept_valid)
        else $error("accept without verdict");
    chk_id_mask: assert property (
        rx_valid && &w_q && ok_r && ok_e |=> rx_accept == $past(idm))
        else $error("identifier filter wrong");
    chk_rtr_mask: assert property (rx_valid && &w_q && !ok_r |=> !rx_accept)
        else $error("remote mismatch accepted");
    chk_ide_mask: assert property (rx_valid && &w_q && !ok_e |=> !rx_accept)
        else $error("format mismatch accepted");
    chk_tx_ext: assert property (
        &w_q && ext_format |-> tx_id == tg && tx_rtr == r_q[3][2])
        else $error("extended tag layout wrong");
    chk_tx_std: assert property (
        &w_q && !ext_format |-> tx_id == tg && tx_rtr == r_q[3][2])
        else $error("standard tag layout wrong");
    chk_read_back: assert property (
        sfr_rd && map && w_q[ix] |=> sfr_hit && sfr_rdata == $past(r_q[ix]))
        else $error("read back differs");
    chk_unmapped_rd: assert property (
        sfr_rd && !map |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("unmapped read answered");
endmodule
bind can_id_tag_mask_filter id_filter_props u_props (.clk_sys, .srst, .sfr_wr, .sfr_rd,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit, .ext_format, .rx_valid, .rx_id, .rx_ide,
    .rx_rtr, .rx_accept, .rx_accept_valid, .tx_id, .tx_rtr);
`default_nettype wire

// File: test/can_id_tag_mask_filter_tb.sv
// Purpose: directed checks of the tag and mask filter
// Assumes: inputs change on the falling clock edge
// Notes: reserved bits written as zero, except reserved0 (bit 0) of the standard fourth tag
`timescale 1ns/1ps
`default_nettype none
module can_id_tag_mask_filter_tb;
    logic clk_sys = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, ext_format = 1'b1;
    logic rx_valid = 1'b0, rx_ide = 1'b0, rx_rtr = 1'b0;
    logic sfr_hit, rx_accept, rx_accept_valid, tx_rtr, tx_ide;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [28:0] rx_id = 29'h0, tx_id, tid;
    int n_fail = 0, checks_done = 0;
    always #2.5 clk_sys = ~clk_sys;
    can_id_tag_mask_filter dut (.clk_sys, .srst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
        .sfr_rdata, .sfr_hit, .ext_format, .rx_valid, .rx_id, .rx_ide, .rx_rtr, .rx_accept,
        .rx_accept_valid, .tx_id, .tx_rtr, .tx_ide);
    // ----------------------------------------
    // Bus and frame tasks
    // ----------------------------------------
    task automatic chk(input logic [28:0] got, input logic [28:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
        @(negedge clk_sys);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk(sfr_hit, h, "hit flag");
        chk(sfr_rdata, d, "read data");
    endtask
    task automatic fr(input logic [28:0] id, input logic e, input logic r, input logic a);
        @(negedge clk_sys);
        rx_valid = 1'b1;
        rx_id = id;
        rx_ide = e;
        rx_rtr = r;
        @(negedge clk_sys);
        rx_valid = 1'b0;
        chk(rx_accept_valid, 1'b1, "verdict strobe");
        chk(rx_accept, a, "accept");
    endtask
    task automatic ext_case();
        ext_format = 1'b1;
        wr(8'hBC, 8'hA5);
        wr(8'hBD, 8'h3C);
        wr(8'hBE, 8'h96);
        wr(8'hBF, 8'hAC);
        for (int i = 0; i < 3; i++) wr(8'hC4 + 8'(i), 8'hFF);
        wr(8'hC7, 8'hFD);
        tid = {8'hA5, 8'h3C, 8'h96, 5'h15};
        chk(tx_id, tid, "extended tag");
        chk(tx_rtr, 1'b1, "remote tag");
        chk(tx_ide, 1'b1, "long format flag");
        rd(8'hBF, 8'hAC, 1'b1);
        fr(tid, 1'b1, 1'b1, 1'b1);
        fr(tid ^ 29'h1, 1'b1, 1'b1, 1'b0);
        fr(tid, 1'b1, 1'b0, 1'b0);
        fr(tid, 1'b0, 1'b1, 1'b0);
        wr(8'hC4, 8'h7F);
        wr(8'hC7, 8'hF0);
        chk(tx_id, tid, "tag after mask write");
        fr(tid ^ 29'h10000001, 1'b0, 1'b0, 1'b1);
        fr(tid ^ 29'h08000000, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic std_case();
        ext_format = 1'b0;
        wr(8'hBC, 8'h5A);
        wr(8'hBD, 8'hC0);
        wr(8'hBF, 8'h05);
        wr(8'hC4, 8'hFF);
        wr(8'hC5, 8'hE0);
        wr(8'hC7, 8'h05);
        wr(8'hBE, 8'h00);
        wr(8'hC6, 8'h00);
        tid = {18'h0, 8'h5A, 3'b110};
        chk(tx_id, tid, "standard tag");
        chk(tx_rtr, 1'b1, "standard remote tag");
        chk(tx_ide, 1'b0, "short format flag");
        fr(tid, 1'b0, 1'b1, 1'b1);
        fr(tid ^ 29'h1, 1'b0, 1'b1, 1'b0);
        fr(tid ^ 29'h400, 1'b0, 1'b1, 1'b0);
        fr(tid, 1'b1, 1'b1, 1'b0);
        rd(8'hC5, 8'hE0, 1'b1);
        rd(8'hC0, 8'h00, 1'b0);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        ext_case();
        std_case();
        summarize();
    end
    // Whole run needs well under a microsecond
    initial begin
        #5000;
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
